// [logic/slc_config_regs.v]
`timescale 1ns/1ns
`include "slc_map.vh"
module slc_config_regs #(
    parameter [7:0] PRODUCT_CODE = 8'h5A // arbitrary value
) (
    // clock and reset
    input  wire       CLK,
    input  wire       RST_N,
    // register port
    input  wire [7:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    input  wire       REG_WR,
    output reg  [7:0] REG_RDATA,
    output wire       REG_HIT,
    // mode and frame timing
    input  wire       I2C_MODE,
    input  wire       SPI_CMD_START,
    // spi source routing
    output wire [3:0] SRC0_ID,
    output wire [3:0] SRC1_ID,
    output wire       SRC0_SEND_DATA,
    output wire       SRC1_SEND_DATA,
    output wire       SRC0_SEND_ERROR,
    output wire       SRC1_SEND_ERROR,
    // i2c read wrap control
    output wire [1:0] I2C_WRAP_SEL,
    // active spi frame settings
    output reg        FIELD_16BIT,
    output reg  [3:0] CHECK_LEN,
    output reg  [7:0] CHECK_POLY,
    output reg  [7:0] CHECK_SEED,
    // integrity check input
    output wire [31:0] CHECK_IMAGE
);
    // ==========================================================
    // register slots
    localparam [1:0] IDX_SRC0   = 2'h0;
    localparam [1:0] IDX_SRC1   = 2'h1;
    localparam [1:0] IDX_SPICFG = 2'h2;
    localparam [1:0] IDX_PRODID = 2'h3;
    localparam       N_SRC      = 2;
    localparam       REG_W      = 8;

    // ==========================================================
    // storage
    reg  [7:0]       src0_r;
    reg  [7:0]       src1_r;
    reg  [7:0]       cfg_r;
    reg  [7:0]       prod_r;
    reg  [7:0]       rdata_nxt;

    wire             hit_nxt;
    wire [1:0]       idx_nxt;
    wire             wr_src0;
    wire             wr_src1;
    wire             wr_cfg;
    wire             wr_prod;
    wire [7:0]       prod_view;

    wire [15:0]      src_pack;
    wire [N_SRC-1:0] src_en;
    wire [N_SRC-1:0] send_data;
    wire [N_SRC-1:0] send_error;

    wire [3:0]       len_nxt;
    wire [7:0]       poly_nxt;
    wire [7:0]       seed_nxt;

    // ==========================================================
    // address decode, shared by the write and read paths
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `SLC_ADDR_SRC0) || (a == `SLC_ADDR_SRC1) ||
                        (a == `SLC_ADDR_SPICFG) || (a == `SLC_ADDR_PRODID);
        end
    endfunction

    // slot number of a mapped address; unmapped addresses give slot 0
    function [1:0] reg_index;
        input [7:0] a;
        begin
            case (a)
                `SLC_ADDR_SRC0:   reg_index = IDX_SRC0;
                `SLC_ADDR_SRC1:   reg_index = IDX_SRC1;
                `SLC_ADDR_SPICFG: reg_index = IDX_SPICFG;
                `SLC_ADDR_PRODID: reg_index = IDX_PRODID;
                default:          reg_index = IDX_SRC0;
            endcase
        end
    endfunction

    assign hit_nxt = is_mapped(REG_ADDR);
    assign idx_nxt = reg_index(REG_ADDR);
    assign REG_HIT = hit_nxt;

    // writes to unmapped addresses are dropped before any slot sees them
    assign wr_src0 = REG_WR && hit_nxt && (idx_nxt == IDX_SRC0);
    assign wr_src1 = REG_WR && hit_nxt && (idx_nxt == IDX_SRC1);
    assign wr_cfg  = REG_WR && hit_nxt && (idx_nxt == IDX_SPICFG);
    assign wr_prod = REG_WR && hit_nxt && (idx_nxt == IDX_PRODID);

    // ==========================================================
    // register slots; reserved bits are stored whole, no field mask
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            src0_r <= `SLC_RST_REG;
        end else if (wr_src0) begin
            src0_r <= REG_WDATA;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            src1_r <= `SLC_RST_REG;
        end else if (wr_src1) begin
            src1_r <= REG_WDATA;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_r <= `SLC_RST_REG;
        end else if (wr_cfg) begin
            cfg_r <= REG_WDATA;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prod_r <= `SLC_RST_REG;
        end else if (wr_prod) begin
            prod_r <= REG_WDATA;
        end
    end

    // ==========================================================
    // read path
    // a stored zero stands for the fixed product code
    assign prod_view = (prod_r == `SLC_RST_REG) ? PRODUCT_CODE : prod_r;

    always @* begin
        rdata_nxt = `SLC_RD_NONE;
        if (hit_nxt) begin
            case (reg_index(REG_ADDR))
                IDX_SRC0:   rdata_nxt = src0_r;
                IDX_SRC1:   rdata_nxt = src1_r;
                IDX_SPICFG: rdata_nxt = cfg_r;
                IDX_PRODID: rdata_nxt = prod_view;
                default:    rdata_nxt = `SLC_RD_NONE;
            endcase
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= `SLC_RD_NONE;
        end else begin
            REG_RDATA <= rdata_nxt;
        end
    end

    // ==========================================================
    // source routing, one lane per channel
    assign src_pack = {src1_r, src0_r};

    genvar ch;
    generate
        for (ch = 0; ch < N_SRC; ch = ch + 1) begin : g_src
            assign src_en[ch]     = src_pack[ch * REG_W + `SLC_SRC_EN_BIT];
            // spi mode only; in i2c mode both lanes stay quiet
            assign send_data[ch]  = !I2C_MODE && src_en[ch];
            assign send_error[ch] = !I2C_MODE && !src_en[ch];
        end
    endgenerate

    assign SRC0_ID         = src0_r[`SLC_SRC_ID_HI:`SLC_SRC_ID_LO];
    assign SRC1_ID         = src1_r[`SLC_SRC_ID_HI:`SLC_SRC_ID_LO];
    assign SRC0_SEND_DATA  = send_data[0];
    assign SRC1_SEND_DATA  = send_data[1];
    assign SRC0_SEND_ERROR = send_error[0];
    assign SRC1_SEND_ERROR = send_error[1];
    // the enable bits steer sequential read wrap only in i2c mode
    assign I2C_WRAP_SEL    = I2C_MODE ? src_en : 2'h0;

    // ==========================================================
    // check settings, latched at command start
    slc_crc_select u_sel (
        .cfg      (cfg_r),
        .chk_len  (len_nxt),
        .chk_poly (poly_nxt),
        .chk_seed (seed_nxt)
    );

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FIELD_16BIT <= 1'b0;
            CHECK_LEN   <= `SLC_CHK_8;
            CHECK_POLY  <= `SLC_POLY_CRC8;
            CHECK_SEED  <= `SLC_SEED_DEF8;
        end else if (SPI_CMD_START) begin
            FIELD_16BIT <= cfg_r[`SLC_CFG_SIZE_BIT];
            CHECK_LEN   <= len_nxt;
            CHECK_POLY  <= poly_nxt;
            CHECK_SEED  <= seed_nxt;
        end
    end

    assign CHECK_IMAGE = {prod_r, cfg_r, src1_r, src0_r};
endmodule

// [logic/slc_crc_select.v]
`timescale 1ns/1ns
`include "slc_map.vh"
// ==========================================================
// check polynomial and seed decode from the configuration byte
module slc_crc_select (
    // configuration
    input  wire [7:0] cfg,
    // decoded check parameters
    output reg  [3:0] chk_len,
    output reg  [7:0] chk_poly,
    output reg  [7:0] chk_seed
);
    wire [3:0] seed_f;
    assign seed_f = cfg[`SLC_CFG_SEED_HI:`SLC_CFG_SEED_LO];

    always @* begin
        case (cfg[`SLC_CFG_LEN_HI:`SLC_CFG_LEN_LO])
            `SLC_LEN_CRC8: begin
                chk_len  = `SLC_CHK_8;
                chk_poly = `SLC_POLY_CRC8;
                chk_seed = (seed_f == 4'h0) ? `SLC_SEED_DEF8 : {4'h0, seed_f};
            end
            `SLC_LEN_CRC4: begin
                chk_len  = `SLC_CHK_4;
                chk_poly = `SLC_POLY_CRC4;
                chk_seed = (seed_f == 4'h0) ? `SLC_SEED_DEF4 : {4'h0, seed_f};
            end
            default: begin
                chk_len  = `SLC_CHK_3;
                chk_poly = `SLC_POLY_CRC3;
                chk_seed = (seed_f == 4'h0) ? `SLC_SEED_DEF3 : {5'h00, seed_f[2:0]};
            end
        endcase
    end
endmodule

// [logic/slc_map.vh]
`ifndef SLC_MAP_VH
`define SLC_MAP_VH
// ==========================================================
// register offsets
`define SLC_ADDR_SRC0      8'h1A
`define SLC_ADDR_SRC1      8'h1B
`define SLC_ADDR_SPICFG    8'h3D
`define SLC_ADDR_PRODID    8'h3E
// ==========================================================
// reset values
`define SLC_RST_REG        8'h00
`define SLC_RD_NONE        8'h00
// ==========================================================
// field positions
`define SLC_SRC_EN_BIT     7
`define SLC_SRC_ID_HI      3
`define SLC_SRC_ID_LO      0
`define SLC_CFG_SIZE_BIT   6
`define SLC_CFG_LEN_HI     5
`define SLC_CFG_LEN_LO     4
`define SLC_CFG_SEED_HI    3
`define SLC_CFG_SEED_LO    0
// ==========================================================
// check encodings
`define SLC_LEN_CRC8       2'h0
`define SLC_LEN_CRC4       2'h1
`define SLC_POLY_CRC8      8'h2F
`define SLC_POLY_CRC4      8'h01
`define SLC_POLY_CRC3      8'h03
`define SLC_SEED_DEF8      8'hFF
`define SLC_SEED_DEF4      8'h0A
`define SLC_SEED_DEF3      8'h07
`define SLC_WIDTH_12       5'h0C
`define SLC_WIDTH_16       5'h10
`define SLC_CHK_8          4'h8
`define SLC_CHK_4          4'h4
`define SLC_CHK_3          4'h3
`endif

// [verification/slc_host.sv]
`timescale 1ns/1ns
// ====================
// host side of the register port
module slc_host (
    input              CLK,
    input        [7:0] REG_RDATA,
    output logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00,
    output logic       REG_WR = 1'b0
);
    task wr(input [7:0] a, input [7:0] v);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
        REG_WDATA <= ~v;
    endtask
    task rd(input [7:0] a, output [7:0] v);
        @(posedge CLK);
        REG_ADDR <= a;
        @(posedge CLK);
        @(negedge CLK);
        v = REG_RDATA;
    endtask
endmodule

// [verification/slc_monitor.sv]
`timescale 1ns/1ns
// ====================
// port checker
module slc_monitor (
    input        CLK, RST_N, REG_WR, REG_HIT, I2C_MODE, SPI_CMD_START, SRC0_SEND_DATA, FIELD_16BIT,
    input [1:0]  I2C_WRAP_SEL,
    input [3:0]  CHECK_LEN,
    input [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, CHECK_POLY,
    input [31:0] CHECK_IMAGE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_hit; REG_HIT == (REG_ADDR inside {8'h1A, 8'h1B, 8'h3D, 8'h3E}); endproperty
    a_hit: assert property (p_hit) else $error("hit");
    property p_unm; !REG_HIT |=> REG_RDATA == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped");
    property p_wr; REG_WR && REG_ADDR == 8'h1A |=> CHECK_IMAGE[7:0] == $past(REG_WDATA); endproperty
    a_wr: assert property (p_wr) else $error("store");
    property p_snd; SRC0_SEND_DATA == (!I2C_MODE && CHECK_IMAGE[7]); endproperty
    a_snd: assert property (p_snd) else $error("route");
    property p_wrap; I2C_WRAP_SEL == (I2C_MODE ? {CHECK_IMAGE[15], CHECK_IMAGE[7]} : 2'h0); endproperty
    a_wrap: assert property (p_wrap) else $error("wrap");
    property p_hold; !SPI_CMD_START |=> $stable(CHECK_LEN) && $stable(FIELD_16BIT); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_fld; SPI_CMD_START |=> FIELD_16BIT == $past(CHECK_IMAGE[22]); endproperty
    a_fld: assert property (p_fld) else $error("field");
    property p_c4; SPI_CMD_START && CHECK_IMAGE[21:20] == 2'h1 |=> CHECK_POLY == 8'h01 && CHECK_LEN == 4'h4; endproperty
    a_c4: assert property (p_c4) else $error("crc4");
endmodule
bind slc_config_regs slc_monitor mon (.*);

// [verification/testbench.sv]
`timescale 1ns/1ns
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value %0t %s", $time, m); end end
// ====================
// register bank bench
module testbench;
    logic        CLK = 0, RST_N = 0, I2C_MODE = 0, SPI_CMD_START = 0, REG_WR, REG_HIT, FIELD_16BIT;
    logic        SRC0_SEND_DATA, SRC1_SEND_DATA, SRC0_SEND_ERROR, SRC1_SEND_ERROR;
    logic [1:0]  I2C_WRAP_SEL;
    logic [3:0]  SRC0_ID, SRC1_ID, CHECK_LEN;
    logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, CHECK_POLY, CHECK_SEED, d;
    logic [7:0]  ad [4] = '{8'h1A, 8'h1B, 8'h3D, 8'h3E};
    logic [7:0]  wv [4] = '{8'hF5, 8'h7A, 8'hC0, 8'h01};
    logic [31:0] CHECK_IMAGE;
    logic [31:0] tbl [6] = '{32'h00082FFF, 32'h05082F05, 32'h1004010A, 32'h1C04010C, 32'h60130307, 32'h3E030306};
    int          n_fail = 0, num_checks = 0, cyc = 0;
    slc_config_regs #(.PRODUCT_CODE(8'h3C)) uut (.*);
    slc_host host (.*);
    always #20 CLK = ~CLK;
    always @(posedge CLK) if (++cyc == 3000) begin
        n_fail++;
        end_of_test;
    end
    task end_of_test;
        if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RST_N <= 1;
        foreach (ad[i]) begin
            host.rd(ad[i], d);
            `CHK(d, (i == 3) ? 8'h3C : 8'h00, "reset")
            host.wr(ad[i], wv[i]);
            host.rd(ad[i], d);
            `CHK(d, wv[i], "readback")
        end
        host.wr(8'h1C, 8'hAA);
        host.rd(8'h1C, d);
        `CHK({REG_HIT, d}, 9'h000, "unmapped")
        `CHK({SRC0_ID, SRC1_ID, SRC0_SEND_ERROR, SRC1_SEND_ERROR, SRC0_SEND_DATA, SRC1_SEND_DATA}, 12'h5A6, "route")
        `CHK(CHECK_IMAGE, 32'h01C07AF5, "image")
        @(posedge CLK) I2C_MODE <= 1;
        @(negedge CLK) `CHK({I2C_WRAP_SEL, SRC0_SEND_DATA, SRC1_SEND_DATA, SRC0_SEND_ERROR, SRC1_SEND_ERROR}, 6'h10, "i2c")
        @(posedge CLK) I2C_MODE <= 0;
        foreach (tbl[i]) begin
            host.wr(8'h3D, tbl[i][31:24]);
            @(negedge CLK) `CHK({FIELD_16BIT, CHECK_LEN, CHECK_POLY, CHECK_SEED}, tbl[(i == 0) ? 0 : i - 1][20:0], "early")
            @(posedge CLK) SPI_CMD_START <= 1;
            @(posedge CLK) SPI_CMD_START <= 0;
            @(negedge CLK) `CHK({FIELD_16BIT, CHECK_LEN, CHECK_POLY, CHECK_SEED}, tbl[i][20:0], "crc")
        end
        end_of_test;
    end
endmodule
